// [dsivc_regs.svh]
// Register offsets, field positions and reset values
`ifndef DSIVC_REGS_SVH
`define DSIVC_REGS_SVH
`define DSIVC_IDX_VIDEO  8'hB6
`define DSIVC_IDX_LINK   8'hB7
`define DSIVC_IDX_VC     8'hB8
`define DSIVC_IDX_PLL    8'hB9
`define DSIVC_IDX_STATUS 8'hC8
`define DSIVC_RST_VIDEO  16'h0024
`define DSIVC_RST_LINK   16'h0301
`define DSIVC_RST_VC     16'h0045
`define DSIVC_RST_PLL    16'h0000
`define DSIVC_WM_VIDEO   16'hE1FF
`define DSIVC_WM_LINK    16'h0FFF
`define DSIVC_WM_VC      16'h00FF
`define DSIVC_WM_PLL     16'h0001
`define DSIVC_B_VSP      15
`define DSIVC_B_HSP      14
`define DSIVC_B_PCP      13
`define DSIVC_B_CBM      8
`define DSIVC_B_NVB      7
`define DSIVC_B_NVD      6
`define DSIVC_B_BLLP     5
`define DSIVC_B_VCS      4
`define DSIVC_B_VM       2
`define DSIVC_B_PF       0
`define DSIVC_B_TXD      11
`define DSIVC_B_LPE      10
`define DSIVC_B_EOT      9
`define DSIVC_B_ECD      8
`define DSIVC_B_REN      7
`define DSIVC_B_DCS      6
`define DSIVC_B_CSS      5
`define DSIVC_B_HCLK     4
`define DSIVC_B_VEN      3
`define DSIVC_B_SLP      2
`define DSIVC_B_CKE      1
`define DSIVC_B_HS       0
`define DSIVC_B_VCM      6
`define DSIVC_B_VCE      4
`define DSIVC_B_VC2      2
`define DSIVC_B_VC1      0
`define DSIVC_B_PEN      0
`endif

// [dsivc_pkg.sv]
// Types shared by the video configuration register bank
package dsivc_pkg;
  typedef enum logic [1:0] {
    DSIVC_SYNC_PULSE = 2'h0,
    DSIVC_SYNC_EVENT = 2'h1,
    DSIVC_BURST      = 2'h2,
    DSIVC_VM_RSVD    = 2'h3
  } dsivc_scheme_e;
  typedef enum logic [1:0] {
    DSIVC_PF16  = 2'h0,
    DSIVC_PF18P = 2'h1,
    DSIVC_PF18L = 2'h2,
    DSIVC_PF24  = 2'h3
  } dsivc_format_e;
  typedef enum logic [2:0] {
    DSIVC_GEN_SHORT_WR = 3'h0,
    DSIVC_GEN_LONG_WR  = 3'h1,
    DSIVC_DCS_SHORT_WR = 3'h2,
    DSIVC_DCS_LONG_WR  = 3'h3,
    DSIVC_GEN_READ     = 3'h4,
    DSIVC_DCS_READ     = 3'h5
  } dsivc_kind_e;
  typedef struct packed {
    logic        pclk;
    logic        vsync;
    logic        hsync;
    logic        den;
    logic [23:0] data;
  } dsivc_rgb_s;
  typedef struct packed {
    logic        in_bllp;
    logic        in_vblank;
    logic        nonvideo_pending;
    logic        reverse_comm;
    logic        data_pending;
    logic        if_rgb_spi;
    logic        pkt_req;
    logic        pkt_from_spi;
    logic [15:0] payload_len;
    logic        hs_tx_end;
    logic        mrs_req;
  } dsivc_ctl_s;
  typedef struct packed {
    logic data_hs;
    logic clk_hs;
    logic blank_fill;
    logic nonvideo_go;
    logic nonvideo_lp;
  } dsivc_lane_s;
  typedef struct packed {
    logic [15:0] video;
    logic [15:0] link;
    logic [15:0] virtual_channel_control;
    logic [15:0] pll;
    logic        css_eff;
    logic        waitreq;
    logic [31:0] rdata;
    dsivc_rgb_s  s1;
    dsivc_rgb_s  s2;
    dsivc_rgb_s  s3;
    dsivc_rgb_s  stable;
    logic        vs_act;
    logic        hs_act;
    logic [23:0] pix;
    logic        pix_vld;
    dsivc_lane_s lane;
    logic        blank_hsync;
    logic        video_run;
    logic [7:0]  pending;
    logic        full;
    logic        go;
    dsivc_kind_e kind;
    logic [1:0]  pvc;
    logic        eot_go;
    logic [1:0]  evc;
    logic        mrs_go;
    logic [1:0]  mvc;
    logic        rx_chk;
    logic        awake;
  } dsivc_state_s;
endpackage

// [dsivc_video_config_regs.sv]
// Contract
// [R1] Sync input polarity set per bit
// [R2] Pixel capture edge chosen by polarity bit
// [R3] Compressed burst drops blanking after hsync
// [R4] Burst non-video only in vblank if set
// [R5] Non-video HS or LP; LP holds BLLP
// [R6] Non-burst HS: fill BLLP blank or LP
// [R7] Burst never blanks; non-burst LP stays LP
// [R8] Host sizes blanking for slow LP
// [R9] Clock lane suspend only in burst
// [R10] Video scheme field, 11 reserved
// [R11] Pixel format masks parallel data bits
// [R12] Transmit disable holds, release bursts all
// [R13] Force long packet for small payloads
// [R14] EOT packet appended when enabled
// [R15] Return packet checks unless disabled
// [R16] Read bit selects read or write
// [R17] Class bit selects generic or DCS
// [R18] PLL source changes only while PLL off
// [R19] Clock lane HS or LP, reverse uses HCLK
// [R20] Video runs only when enabled, RGB+SPI
// [R21] Sleep clears HS; HS bit selects mode
// [R22] Separate channel IDs per packet class; code picks the ID by source (SPI or not), plus own IDs for EOT and MRS
// [R23] PLL enable powers PLL up or down
// [R24] Channel ID placed in packet header
`timescale 1ns/1ps
`include "dsivc_regs.svh"
module dsivc_video_config_regs
  import dsivc_pkg::*;
#(
  parameter int HOLD_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  input  wire dsivc_rgb_s  rgb_in,
  input  wire dsivc_ctl_s  ctl,
  output      logic        vsync_active,
  output      logic        hsync_active,
  output      logic [23:0] pixel_data,
  output      logic        pixel_valid,
  output      dsivc_lane_s lane,
  output      logic        blank_after_hsync,
  output      logic        video_running,
  output      logic        pkt_go,
  output      dsivc_kind_e pkt_kind,
  output      logic [1:0]  pkt_vc,
  output      logic        hold_full,
  output      logic        eot_go,
  output      logic [1:0]  eot_vc,
  output      logic        mrs_go,
  output      logic [1:0]  mrs_vc,
  output      logic        rx_check_en,
  output      logic        pll_enable,
  output      logic        pll_source_pclk,
  output      logic        core_awake
);

  if (HOLD_DEPTH < 1 || HOLD_DEPTH > 255) begin : g_chk
    $error("HOLD_DEPTH must lie in 1..255");
  end

  localparam logic [7:0] DEPTH = 8'(HOLD_DEPTH);

  logic [1:0]   rst_sync;
  logic         rst_n;
  dsivc_state_s st_reg;
  dsivc_state_s st_next;

  // Reset release through two flops, assert stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [7:0]    idx;
  logic [15:0]   be_mask;
  logic [15:0]   wval;
  logic          wr_hit;
  logic          burst;
  logic          vrun;
  logic          nv_window;
  logic          capture;
  logic          rise;
  logic          fall;
  logic          inc;
  logic          dec;
  logic          short_ok;
  dsivc_kind_e   kind_now;
  dsivc_rgb_s    stab_n;
  dsivc_format_e fmt;

  always_comb begin
    st_next = st_reg;
    idx     = avs_address[9:2];
    be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wval    = avs_writedata[15:0] & be_mask;
    wr_hit  = avs_write && !st_reg.waitreq;

    // Bus: one wait cycle, then the answer; reads of holes give zero
    st_next.waitreq = !((avs_read || avs_write) && st_reg.waitreq);
    if (avs_read && st_reg.waitreq) begin
      unique case (idx)
        `DSIVC_IDX_VIDEO:  st_next.rdata = {16'h0000, st_reg.video};
        `DSIVC_IDX_LINK:   st_next.rdata = {16'h0000, st_reg.link};
        `DSIVC_IDX_VC:     st_next.rdata = {16'h0000, st_reg.virtual_channel_control};
        `DSIVC_IDX_PLL:    st_next.rdata = {16'h0000, st_reg.pll};
        `DSIVC_IDX_STATUS: st_next.rdata = {16'h0000, st_reg.pending,
                                            st_reg.full, st_reg.css_eff,
                                            st_reg.video_run,
                                            st_reg.lane.data_hs,
                                            st_reg.lane.clk_hs,
                                            st_reg.lane.blank_fill,
                                            st_reg.lane.nonvideo_go,
                                            st_reg.lane.nonvideo_lp};
        default:           st_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_hit) begin
      unique case (idx)
        `DSIVC_IDX_VIDEO: st_next.video = ((st_reg.video & ~be_mask) | wval)
                                          & `DSIVC_WM_VIDEO;
        `DSIVC_IDX_LINK:  st_next.link = ((st_reg.link & ~be_mask) | wval)
                                         & `DSIVC_WM_LINK;
        `DSIVC_IDX_VC:    st_next.virtual_channel_control = ((st_reg.virtual_channel_control & ~be_mask) | wval)
                                        & `DSIVC_WM_VC;
        `DSIVC_IDX_PLL:   st_next.pll = ((st_reg.pll & ~be_mask) | wval)
                                        & `DSIVC_WM_PLL;
        default: ;
      endcase
    end
    // [R21] Sleep clears HS
    if (st_next.link[`DSIVC_B_SLP]) begin
      st_next.link[`DSIVC_B_HS] = 1'b0;
    end
    // Level outputs registered so every pin leaves a flop
    st_next.awake  = !st_next.link[`DSIVC_B_SLP];
    // [R15] Check unless disabled
    st_next.rx_chk = !st_next.link[`DSIVC_B_ECD];
    // [R18] Latch source while off
    if (!st_reg.pll[`DSIVC_B_PEN]) begin
      st_next.css_eff = st_reg.link[`DSIVC_B_CSS];
    end

    // Pin inputs: three flops, a change counts once stages two and three agree
    st_next.s1     = rgb_in;
    st_next.s2     = st_reg.s1;
    st_next.s3     = st_reg.s2;
    stab_n         = (st_reg.s2 ~^ st_reg.s3) & st_reg.s3
                   | (st_reg.s2 ^ st_reg.s3) & st_reg.stable;
    st_next.stable = stab_n;
    rise = !st_reg.stable.pclk && stab_n.pclk;
    fall = st_reg.stable.pclk && !stab_n.pclk;
    // [R2] Select capture edge
    capture = st_reg.video[`DSIVC_B_PCP] ? fall : rise;
    // [R1] Normalise sync polarity
    st_next.vs_act = !(stab_n.vsync ^ st_reg.video[`DSIVC_B_VSP]);
    st_next.hs_act = !(stab_n.hsync ^ st_reg.video[`DSIVC_B_HSP]);
    st_next.pix_vld = capture && stab_n.den;
    fmt = dsivc_format_e'(st_reg.video[`DSIVC_B_PF +: 2]);
    if (capture && stab_n.den) begin
      // [R11] Mask unused data bits
      unique case (fmt)
        DSIVC_PF16:  st_next.pix = {8'h00, stab_n.data[15:0]};
        DSIVC_PF18P,
        DSIVC_PF18L: st_next.pix = {6'h00, stab_n.data[17:0]};
        DSIVC_PF24:  st_next.pix = stab_n.data;
      endcase
    end

    // [R10] Scheme decode, reserved code runs no video
    burst = st_reg.video[`DSIVC_B_VM +: 2] == DSIVC_BURST;
    // [R20] Video gated by enable and interface
    vrun  = st_reg.link[`DSIVC_B_VEN] && ctl.if_rgb_spi
         && !st_reg.link[`DSIVC_B_SLP]
         && st_reg.video[`DSIVC_B_VM +: 2] != DSIVC_VM_RSVD;
    st_next.video_run = vrun;
    // [R3] Compressed burst drops blanking
    st_next.blank_hsync = !(burst && st_reg.video[`DSIVC_B_CBM]);
    // [R4] Burst non-video window
    nv_window = burst ? (!st_reg.video[`DSIVC_B_NVB] || ctl.in_vblank)
                      : ctl.in_vblank;
    st_next.lane.nonvideo_go = vrun && ctl.in_bllp
                            && ctl.nonvideo_pending && nv_window;
    // [R5] Non-video over LP
    st_next.lane.nonvideo_lp = st_next.lane.nonvideo_go
                            && st_reg.video[`DSIVC_B_NVD];
    st_next.lane.blank_fill = 1'b0;
    if (!vrun) begin
      // [R21] HS bit picks mode
      st_next.lane.data_hs = st_reg.link[`DSIVC_B_HS] && ctl.data_pending;
    end else if (!ctl.in_bllp) begin
      st_next.lane.data_hs = 1'b1;
    end else if (burst) begin
      // [R7] Burst BLLP goes LP unless non-video is sent over HS
      st_next.lane.data_hs = st_next.lane.nonvideo_go
                          && !st_reg.video[`DSIVC_B_NVD];
    end else if (st_reg.video[`DSIVC_B_NVD]) begin
      // [R5] LP for whole BLLP
      st_next.lane.data_hs = 1'b0;
    end else begin
      // [R6] Blank or LP fill
      st_next.lane.data_hs = st_next.lane.nonvideo_go
                          || !st_reg.video[`DSIVC_B_BLLP];
      st_next.lane.blank_fill = !st_next.lane.nonvideo_go
                             && !st_reg.video[`DSIVC_B_BLLP];
    end
    if (st_reg.link[`DSIVC_B_SLP]) begin
      st_next.lane.clk_hs = 1'b0;
    end else if (vrun) begin
      // [R9] Suspend clock only in burst
      st_next.lane.clk_hs = !burst || !st_reg.video[`DSIVC_B_VCS]
                         || st_next.lane.data_hs;
    end else begin
      // [R19] Clock lane in command mode
      st_next.lane.clk_hs = st_reg.link[`DSIVC_B_CKE]
                         || (ctl.reverse_comm ? !st_reg.link[`DSIVC_B_HCLK]
                                              : st_next.lane.data_hs);
    end

    // [R12] Hold while disabled, then drain one per cycle
    inc = ctl.pkt_req && st_reg.pending != DEPTH;
    dec = !st_reg.link[`DSIVC_B_TXD] && st_reg.pending != 8'h00;
    st_next.pending = st_reg.pending + {7'h00, inc} - {7'h00, dec};
    st_next.full    = st_next.pending == DEPTH;
    st_next.go      = dec;
    // [R13] Long packet forced when set
    short_ok = st_reg.link[`DSIVC_B_DCS] ? ctl.payload_len <= 16'h0001
                                         : ctl.payload_len <= 16'h0002;
    short_ok = short_ok && !st_reg.link[`DSIVC_B_LPE];
    // [R16] Read or write
    // [R17] Generic or DCS class
    if (st_reg.link[`DSIVC_B_REN]) begin
      kind_now = st_reg.link[`DSIVC_B_DCS] ? DSIVC_DCS_READ : DSIVC_GEN_READ;
    end else if (st_reg.link[`DSIVC_B_DCS]) begin
      kind_now = short_ok ? DSIVC_DCS_SHORT_WR : DSIVC_DCS_LONG_WR;
    end else begin
      kind_now = short_ok ? DSIVC_GEN_SHORT_WR : DSIVC_GEN_LONG_WR;
    end
    // [R22] Channel per source
    // [R24] Header channel with packet
    if (dec) begin
      st_next.kind = kind_now;
      st_next.pvc  = ctl.pkt_from_spi ? st_reg.virtual_channel_control[`DSIVC_B_VC2 +: 2]
                                      : st_reg.virtual_channel_control[`DSIVC_B_VC1 +: 2];
    end
    // [R14] EOT at HS end
    st_next.eot_go = ctl.hs_tx_end && st_reg.link[`DSIVC_B_EOT]
                  && !st_reg.link[`DSIVC_B_SLP];
    if (st_next.eot_go) begin
      st_next.evc = st_reg.virtual_channel_control[`DSIVC_B_VCE +: 2];
    end
    st_next.mrs_go = ctl.mrs_req && !st_reg.link[`DSIVC_B_SLP];
    if (st_next.mrs_go) begin
      st_next.mvc = st_reg.virtual_channel_control[`DSIVC_B_VCM +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.video <= `DSIVC_RST_VIDEO;
      st_reg.link  <= `DSIVC_RST_LINK;
      st_reg.virtual_channel_control   <= `DSIVC_RST_VC;
      st_reg.pll   <= `DSIVC_RST_PLL;
      st_reg.waitreq <= 1'b1;
      st_reg.awake   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata      = st_reg.rdata;
  assign avs_waitrequest   = st_reg.waitreq;
  assign vsync_active      = st_reg.vs_act;
  assign hsync_active      = st_reg.hs_act;
  assign pixel_data        = st_reg.pix;
  assign pixel_valid       = st_reg.pix_vld;
  assign lane              = st_reg.lane;
  assign blank_after_hsync = st_reg.blank_hsync;
  assign video_running     = st_reg.video_run;
  assign pkt_go            = st_reg.go;
  assign pkt_kind          = st_reg.kind;
  assign pkt_vc            = st_reg.pvc;
  assign hold_full         = st_reg.full;
  assign eot_go            = st_reg.eot_go;
  assign eot_vc            = st_reg.evc;
  assign mrs_go            = st_reg.mrs_go;
  assign mrs_vc            = st_reg.mvc;
  // [R15] Check unless disabled
  assign rx_check_en       = st_reg.rx_chk;
  // [R23] PLL power control
  assign pll_enable        = st_reg.pll[`DSIVC_B_PEN];
  assign pll_source_pclk   = st_reg.css_eff;
  assign core_awake        = st_reg.awake;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_pclk_up;
    !st_reg.stable.pclk && !st_reg.video[`DSIVC_B_PCP]
      ##1 st_reg.stable.pclk && st_reg.stable.den;
  endsequence
  sequence s_drain;
    !st_reg.link[`DSIVC_B_TXD] && st_reg.pending != 8'h00;
  endsequence

  a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not pulse low once");
  a_sleep_hs: assert property ( // [R21]
    st_reg.link[`DSIVC_B_SLP] |-> !st_reg.link[`DSIVC_B_HS])
    else $error("HS bit set during sleep");
  a_hold_stop: assert property ( // [R12]
    st_reg.link[`DSIVC_B_TXD] |=> !pkt_go)
    else $error("packet sent while transmit disabled");
  a_hold_drain: assert property (s_drain |=> pkt_go) // [R12]
    else $error("held packet not released");
  a_eot_send: assert property ( // [R14]
    ctl.hs_tx_end && st_reg.link[`DSIVC_B_EOT]
      && !st_reg.link[`DSIVC_B_SLP]
    |=> eot_go && eot_vc == $past(st_reg.virtual_channel_control[`DSIVC_B_VCE +: 2]))
    else $error("EOT missing or wrong channel");
  a_eot_off: assert property ( // [R14]
    !st_reg.link[`DSIVC_B_EOT] |=> !eot_go)
    else $error("EOT sent while disabled");
  a_burst_blank: assert property ( // [R7]
    burst |=> !lane.blank_fill)
    else $error("blanking packet in burst mode");
  a_nonburst_clk: assert property ( // [R9]
    vrun && !burst |=> lane.clk_hs)
    else $error("clock lane left HS in non-burst");
  a_pll_source: assert property ( // [R18]
    st_reg.pll[`DSIVC_B_PEN] |=> $stable(pll_source_pclk))
    else $error("PLL source changed while enabled");
  a_pix_capture: assert property (s_pclk_up |-> pixel_valid) // [R2]
    else $error("pixel not captured on rising edge");
  a_pix_mask: assert property ( // [R11]
    pixel_valid && $past(fmt) == DSIVC_PF16 |-> pixel_data[23:16] == 8'h00)
    else $error("unused pixel bits not masked");
  a_lp_select: assert property ( // [R21]
    !vrun && !st_reg.link[`DSIVC_B_HS] |=> !lane.data_hs)
    else $error("data lane HS with HS bit clear");
  a_check_enable: assert property ( // [R15]
    rx_check_en == !st_reg.link[`DSIVC_B_ECD])
    else $error("return check enable disagrees with bit");
  a_nv_window: assert property ( // [R4]
    burst && st_reg.video[`DSIVC_B_NVB] && !ctl.in_vblank
    |=> !lane.nonvideo_go)
    else $error("non-video sent outside vertical blanking");
  a_nv_lp: assert property ( // [R5]
    vrun && ctl.in_bllp && st_reg.video[`DSIVC_B_NVD] |=> !lane.data_hs)
    else $error("data lane HS in BLLP with LP non-video");
  a_cke_clock: assert property ( // [R19]
    !vrun && !st_reg.link[`DSIVC_B_SLP] && st_reg.link[`DSIVC_B_CKE]
    |=> lane.clk_hs)
    else $error("clock lane left HS with lane enable set");
  a_sleep_awake: assert property ( // [R21]
    st_reg.link[`DSIVC_B_SLP] |-> !core_awake)
    else $error("core awake during sleep");

endmodule

// [dsivc_pixel_src.sv]
// Parallel video source model facing the pixel input pins
`timescale 1ns/1ps
module dsivc_pixel_src
  import dsivc_pkg::*;
(
  input  wire logic        run,
  input  wire logic        pol,
  input  wire logic        vs,
  input  wire logic        hs,
  input  wire logic [23:0] pix,
  output      dsivc_rgb_s  rgb
);
  // Odd start offset keeps pclk edges 3 ns before clk rising edges
  initial begin
    rgb = '0;
    #7;
    forever begin
      rgb.vsync = vs;
      rgb.hsync = hs;
      if (run) begin
        // Launch edge opposite the capture edge
        rgb.pclk = pol;
        rgb.data = pix;
        rgb.den  = 1'b1;
        #80 rgb.pclk = !pol;
        #80;
      end else begin
        // Pclk stands still; released bus must not look valid
        rgb.den  = 1'b0;
        rgb.data = ~rgb.data;
        #20;
      end
    end
  end
endmodule

// [dsi_tx_video_config_regs_tb.sv]
// Self-checking bench for the video configuration register bank
`timescale 1ns/1ps
module dsi_tx_video_config_regs_tb;
  import dsivc_pkg::*;
  typedef struct packed {
    logic        pkt;
    logic [9:0]  a;
    logic [15:0] w;
    logic [15:0] len;
    logic        spi;
    logic [31:0] exp;
  } dsivc_row_s;
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  dsivc_rgb_s  rgb;
  dsivc_ctl_s  ctl;
  dsivc_lane_s lane;
  dsivc_kind_e pkt_kind;
  logic        vsync_active, hsync_active, pixel_valid, blank_after_hsync;
  logic        video_running, pkt_go, hold_full, eot_go, mrs_go;
  logic        rx_check_en, pll_enable, pll_source_pclk, core_awake;
  logic [23:0] pixel_data, src_pix;
  logic [1:0]  pkt_vc, eot_vc, mrs_vc;
  logic        src_run, src_pol, src_vs, src_hs;
  int          n_errors, total_checks, n_go, cycles, n0;
  dsivc_row_s  rows [14];
  wire [3:0]   evs = {pixel_valid, pkt_go, eot_go, mrs_go};

  dsivc_video_config_regs #(.HOLD_DEPTH(2)) u_dut (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rgb_in(rgb), .ctl(ctl), .vsync_active(vsync_active),
    .hsync_active(hsync_active), .pixel_data(pixel_data),
    .pixel_valid(pixel_valid), .lane(lane),
    .blank_after_hsync(blank_after_hsync), .video_running(video_running),
    .pkt_go(pkt_go), .pkt_kind(pkt_kind), .pkt_vc(pkt_vc),
    .hold_full(hold_full), .eot_go(eot_go), .eot_vc(eot_vc),
    .mrs_go(mrs_go), .mrs_vc(mrs_vc), .rx_check_en(rx_check_en),
    .pll_enable(pll_enable), .pll_source_pclk(pll_source_pclk),
    .core_awake(core_awake)
  );
  dsivc_pixel_src u_src (
    .run(src_run), .pol(src_pol), .vs(src_vs), .hs(src_hs),
    .pix(src_pix), .rgb(rgb)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (pkt_go === 1'b1) begin
      n_go++;
    end
    if (cycles == 20000) begin
      n_errors++;
      $display("BAD t=%0t run did not finish", $time);
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [15:0] d, output logic [31:0] r);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ctl.pkt_req    <= (i == 0);
    ctl.hs_tx_end  <= (i == 1);
    ctl.mrs_req    <= (i == 2);
    @(posedge clk);
    ctl.pkt_req    <= 1'b0;
    ctl.hs_tx_end  <= 1'b0;
    ctl.mrs_req    <= 1'b0;
  endtask

  task automatic wait_ev(input int i);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (evs[i] !== 1'b1 && k < 100);
    chk(k < 100, 1'b1);
  endtask

  task automatic done(input string s);
    $display("finished: %s", s);
  endtask

  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    ctl = '0;
    {src_run, src_pol, src_vs, src_hs, src_pix} = '0;
    rows[0]  = '{0, 10'h2D8, 16'hFFFF, 0, 0, 32'hE1FF};
    rows[1]  = '{0, 10'h2DC, 16'hFFFF, 0, 0, 32'h0FFE};
    rows[2]  = '{0, 10'h2E0, 16'h12E4, 0, 0, 32'h00E4};
    rows[3]  = '{0, 10'h2E4, 16'hFFFE, 0, 0, 32'h0000};
    rows[4]  = '{0, 10'h3FC, 16'hFFFF, 0, 0, 32'h0000};
    rows[5]  = '{0, 10'h2DC, 16'h0209, 0, 0, 32'h0209};
    rows[6]  = '{1, 10'h2DC, 16'h0208, 2, 0, 32'h00};
    rows[7]  = '{1, 10'h2DC, 16'h0208, 3, 1, 32'h09};
    rows[8]  = '{1, 10'h2DC, 16'h0248, 1, 0, 32'h02};
    rows[9]  = '{1, 10'h2DC, 16'h0248, 2, 1, 32'h0B};
    rows[10] = '{1, 10'h2DC, 16'h0608, 1, 0, 32'h01};
    rows[11] = '{1, 10'h2DC, 16'h0648, 1, 0, 32'h03};
    rows[12] = '{1, 10'h2DC, 16'h0288, 1, 0, 32'h04};
    rows[13] = '{1, 10'h2DC, 16'h02C8, 1, 1, 32'h0D};
    tick(3);
    rst_b <= 1'b1;
    tick(3);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      if (rows[i].pkt) begin
        ctl.payload_len  <= rows[i].len;
        ctl.pkt_from_spi <= rows[i].spi;
        pulse(0);
        wait_ev(2);
        chk({27'h0, pkt_vc, pkt_kind}, rows[i].exp); // kind
      end else begin
        bus(1'b0, rows[i].a, 16'h0000, q);
        chk(q, rows[i].exp); // stored value
      end
    end
    done("table");
    // Three back-to-back requests into a hold of two
    wr(10'h2DC, 16'h0A08);
    n0 = n_go;
    @(posedge clk);
    ctl.pkt_req <= 1'b1;
    tick(3);
    ctl.pkt_req <= 1'b0;
    tick(3);
    chk(hold_full, 1'b1); // hold full
    chk(n_go - n0, 0); // nothing sent
    wr(10'h2DC, 16'h0208);
    tick(6);
    chk(n_go - n0, 2); // all held sent
    chk(hold_full, 1'b0); // drained
    done("hold");
    pulse(1);
    wait_ev(1);
    chk(eot_vc, 2'b10); // end packet channel
    pulse(2);
    wait_ev(0);
    chk(mrs_vc, 2'b11); // return size channel
    chk(rx_check_en, 1'b1); // checks on
    wr(10'h2DC, 16'h0328);
    tick(2);
    chk(rx_check_en, 1'b0); // checks off
    chk(pll_source_pclk, 1'b1); // source while off
    wr(10'h2E4, 16'h0001);
    tick(2);
    chk(pll_enable, 1'b1); // powered
    wr(10'h2DC, 16'h0208);
    tick(2);
    chk(pll_source_pclk, 1'b1); // locked while on
    wr(10'h2DC, 16'h020D);
    bus(1'b0, 10'h2DC, 16'h0000, q);
    chk(q, 32'h020C); // sleep drops HS
    chk(core_awake, 1'b0); // asleep
    wr(10'h2DC, 16'h0208);
    done("link control");
    ctl.if_rgb_spi <= 1'b1;
    tick(2);
    chk(video_running, 1'b0); // reserved scheme
    wr(10'h2D8, 16'h0004);
    tick(2);
    chk(video_running, 1'b1); // runs
    chk(lane.clk_hs, 1'b1); // non-burst clock HS
    ctl.if_rgb_spi <= 1'b0;
    ctl.in_bllp    <= 1'b1;
    tick(2);
    chk(video_running, 1'b0); // wrong interface
    ctl.if_rgb_spi <= 1'b1;
    tick(2);
    chk(lane.blank_fill, 1'b1); // blanking fill
    wr(10'h2D8, 16'h0108);
    tick(2);
    chk(lane.blank_fill, 1'b0); // burst never blanks
    chk(blank_after_hsync, 1'b0); // compressed
    wr(10'h2D8, 16'h0008);
    tick(2);
    chk(blank_after_hsync, 1'b1); // with blanking
    ctl.nonvideo_pending <= 1'b1;
    tick(2);
    chk(lane.nonvideo_go, 1'b1); // any BLLP
    wr(10'h2D8, 16'h00C8);
    tick(2);
    chk(lane.nonvideo_go, 1'b0); // vblank only
    ctl.in_vblank <= 1'b1;
    tick(2);
    chk(lane.nonvideo_lp, 1'b1); // non-video in LP
    chk(lane.data_hs, 1'b0); // burst BLLP in LP
    ctl.nonvideo_pending <= 1'b0;
    ctl.in_vblank        <= 1'b0;
    ctl.in_bllp          <= 1'b0;
    ctl.if_rgb_spi       <= 1'b0;
    ctl.reverse_comm     <= 1'b1;
    tick(2);
    chk(lane.clk_hs, 1'b1); // reverse, clock HS
    wr(10'h2DC, 16'h0218);
    tick(2);
    chk(lane.clk_hs, 1'b0); // reverse, clock off
    ctl.reverse_comm <= 1'b0;
    ctl.if_rgb_spi   <= 1'b1;
    wr(10'h2DC, 16'h0208);
    done("video scheme");
    for (int f = 0; f < 4; f++) begin
      wr(10'h2D8, {f[0], 1'b0, f[0], 9'h000, 2'b01, f[1:0]});
      src_pol <= f[0];
      src_vs  <= 1'b1;
      src_pix <= 24'hABCDEF ^ f[23:0];
      src_run <= 1'b1;
      wait_ev(3);
      chk(pixel_data, (24'hABCDEF ^ f[23:0]) & ((f == 0) ? 24'h00FFFF :
          (f == 3) ? 24'hFFFFFF : 24'h03FFFF)); // pixel
      chk(vsync_active, f[0]); // vertical polarity
      chk(hsync_active, 1'b1); // horizontal polarity
      src_run <= 1'b0;
      tick(12);
    end
    done("pixels");
    rst_b <= 1'b0;
    tick(3);
    rst_b <= 1'b1;
    tick(3);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 10'h2D8 + 10'(4 * i), 16'h0000, q);
      chk(q, (i == 0) ? 32'h0024 : (i == 1) ? 32'h0301 :
          (i == 2) ? 32'h0045 : 32'h0000); // reset value
    end
    done("reset");
    wrap_up();
  end
endmodule
